// ===== rca_arbiter.v
`timescale 1ns/10ps
`default_nettype none
`include "rca_map.vh"
module rca_arbiter #(
    parameter ACK_CYCLES = `RCA_ACK_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        remote_request_n,
    input  wire        terminal_standby_input,
    input  wire [15:0] voltage_setpoint_input,
    input  wire [15:0] current_setpoint_input,
    input  wire [15:0] power_setpoint_input,
    input  wire [15:0] resistance_setpoint_input,
    input  wire [15:0] voltage_actual,
    input  wire [15:0] current_actual,
    input  wire [5:0]  alarm_event,
    output reg  [15:0] voltage_set,
    output reg  [15:0] current_set,
    output reg  [15:0] power_set,
    output reg  [15:0] resistance_set,
    output reg  [15:0] voltage_monitor_output,
    output reg  [15:0] current_monitor_output,
    output reg         range_10v,
    output reg         terminal_on,
    output reg         alarm_port_1,
    output reg         alarm_port_2,
    output reg         logging_active,
    output reg         analog_active,
    output reg         digital_active
);
    localparam [2:0] ST_MANUAL  = 3'b001;
    localparam [2:0] ST_ANALOG  = 3'b010;
    localparam [2:0] ST_DIGITAL = 3'b100;
    localparam CW = 24;
    // Port 1 carries temperature and supply faults, port 2 the protection trips;
    // safety overvoltage shows on both, so it reads as supply fail plus overvoltage
    localparam [5:0] PORT1_MASK = (6'h01 << `RCA_ALM_OT) | (6'h01 << `RCA_ALM_PF) |
                                  (6'h01 << `RCA_ALM_SAFETY_OVERVOLTAGE_LATCH);
    localparam [5:0] PORT2_MASK = (6'h01 << `RCA_ALM_OVP) | (6'h01 << `RCA_ALM_OCP) |
                                  (6'h01 << `RCA_ALM_OPP) | (6'h01 << `RCA_ALM_SAFETY_OVERVOLTAGE_LATCH);
    // Only the protection trips can be acknowledged from the standby pin
    localparam [5:0] ACK_MASK   = (6'h01 << `RCA_ALM_OVP) | (6'h01 << `RCA_ALM_OCP) |
                                  (6'h01 << `RCA_ALM_OPP);

    // Pins come from another domain
    reg [1:0] rem_sync_reg;
    reg [1:0] sb_sync_reg;
    reg [2:0] state_reg;
    reg [31:0] ctrl_reg;
    reg [15:0] vset_reg;
    reg [15:0] iset_reg;
    reg [15:0] pset_reg;
    reg [15:0] ovp_thr_reg;
    reg [5:0]  almsel_reg;
    reg [5:0]  alarm_reg;
    reg        sb_prev_reg;
    reg [CW-1:0] low_cnt_reg;
    reg        low_long_reg;
    reg        aw_reg;
    reg        w_reg;
    reg [7:0]  awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;
    reg        bvalid_reg;
    reg [1:0]  bresp_reg;
    reg        rvalid_reg;
    reg [1:0]  rresp_reg;
    reg [31:0] rdata_reg;

    wire remote_req = ~rem_sync_reg[1];
    wire standby_hi = sb_sync_reg[1];
    wire locked = ctrl_reg[`RCA_CTRL_LOCK];
    wire [15:0] full = ctrl_reg[`RCA_CTRL_RANGE10] ? `RCA_FULL10 : `RCA_FULL5;

    // Over-range input clamps to full scale [R13] [R14]
    function [15:0] clip;
        input [15:0] v;
        input [15:0] f;
        begin
            clip = (v > f) ? f : v;
        end
    endfunction

    // Registers are whole aligned words; the low address bits are dropped
    function [7:0] word_addr;
        input [7:0] a;
        begin
            word_addr = {a[7:2], 2'b00};
        end
    endfunction

    // An alarm reaches a port only when configured for it [R19]
    function port_alarm;
        input [5:0] latched;
        input [5:0] sel;
        input [5:0] mask;
        begin
            port_alarm = |(latched & sel & mask);
        end
    endfunction

    // Writes land once both address and data are held
    wire do_write = aw_reg & w_reg & ~bvalid_reg;
    wire wr_ctrl = do_write & (awaddr_reg == `RCA_CTRL_OFS);
    wire req_rem = wr_ctrl & wdata_reg[`RCA_CTRL_REQ_REM];
    wire rel_rem = wr_ctrl & wdata_reg[`RCA_CTRL_REL_REM];
    wire refused = req_rem & (locked | state_reg == ST_ANALOG | remote_req); // [R2] [R6]
    // Error answer: refused request, alarm word or unmapped word, partial strobe
    wire wr_error = refused | (awaddr_reg > `RCA_ALMSEL_OFS) | (wstrb_reg != 4'hf);

    // Acknowledge: high, low held long enough, high again [R20] [R23]
    wire ack = standby_hi & ~sb_prev_reg & low_long_reg;
    wire [5:0] alarm_next = (alarm_reg & ~({6{ack}} & ACK_MASK)) | alarm_event; // [R21]
    wire any_alarm = |alarm_event;

    assign s_axi_awready = ~aw_reg;
    assign s_axi_wready  = ~w_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rem_sync_reg <= 2'b11;
            sb_sync_reg  <= 2'b11;
        end else begin
            // A pin change reaches the state machine two edges late
            rem_sync_reg <= {rem_sync_reg[0], remote_request_n};
            sb_sync_reg  <= {sb_sync_reg[0], terminal_standby_input};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            sb_prev_reg  <= 1'b1;
            low_cnt_reg  <= {CW{1'b0}};
            low_long_reg <= 1'b0;
        end else begin
            sb_prev_reg <= standby_hi;
            if (standby_hi) begin
                low_cnt_reg <= {CW{1'b0}};
                if (sb_prev_reg)
                    low_long_reg <= 1'b0;
            // Counter stops at the limit, so a very long low never wraps into a short one
            end else if (low_cnt_reg < ACK_CYCLES[CW-1:0]) begin
                low_cnt_reg <= low_cnt_reg + 1'b1;
            end else begin
                low_long_reg <= 1'b1;
            end
        end
    end

    // Control location
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_MANUAL;
        end else begin
            case (state_reg)
                ST_MANUAL: begin
                    // Analog resumes after lock if pin still asks [R8] [R16] [R5]
                    if (!locked && remote_req)
                        state_reg <= ST_ANALOG;
                    else if (req_rem && !refused)
                        state_reg <= ST_DIGITAL;
                end
                ST_ANALOG: begin
                    // Lock suspends analog; the pin decides again once it clears [R6]
                    if (locked || !remote_req)
                        state_reg <= ST_MANUAL; // [R8]
                end
                ST_DIGITAL: begin
                    // Pin changes ignored here [R3] [R1]
                    if (locked || rel_rem)
                        state_reg <= ST_MANUAL; // [R7]
                end
                default: state_reg <= ST_MANUAL;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= `RCA_CTRL_RST;
            vset_reg    <= 16'h0000;
            iset_reg    <= 16'h0000;
            pset_reg    <= 16'h0000;
            ovp_thr_reg <= `RCA_OVP_THR_RST; // [R15]
            almsel_reg  <= `RCA_ALMSEL_RST;
        end else begin
            if (do_write) begin
                case (awaddr_reg)
                    `RCA_CTRL_OFS: begin
                        // A refused request leaves the whole word untouched [R2]
                        if (!refused)
                            ctrl_reg <= {wdata_reg[31:2], 2'b00};
                    end
                    `RCA_VSET_OFS: vset_reg <= wdata_reg[15:0];
                    `RCA_ISET_OFS: iset_reg <= wdata_reg[15:0];
                    `RCA_PSET_OFS: pset_reg <= wdata_reg[15:0];
                    // Thresholds reach the bus only, never the analog pins [R15]
                    `RCA_OVP_THR_OFS: ovp_thr_reg <= wdata_reg[15:0];
                    `RCA_ALMSEL_OFS: almsel_reg <= wdata_reg[5:0]; // [R19]
                    default: ;
                endcase
            end
            // Alarm switch-off clears the on request too [R18]
            if (any_alarm)
                ctrl_reg[`RCA_CTRL_OUT_ON] <= 1'b0;
        end
    end

    // Latched alarms; a new event wins over an acknowledgement [R20] [R21]
    always @(posedge aclk) begin
        if (!aresetn)
            alarm_reg <= 6'h00;
        else
            alarm_reg <= alarm_next;
    end

    // Ownership flags and range seen by the outside
    always @(posedge aclk) begin
        if (!aresetn) begin
            range_10v      <= 1'b0;
            analog_active  <= 1'b0;
            digital_active <= 1'b0;
        end else begin
            range_10v      <= ctrl_reg[`RCA_CTRL_RANGE10]; // [R12]
            analog_active  <= state_reg == ST_ANALOG;
            digital_active <= state_reg == ST_DIGITAL;
        end
    end

    // Analog values all together, else panel/host; never a mix [R9] [R10] [R11]
    always @(posedge aclk) begin
        if (!aresetn) begin
            voltage_set    <= 16'h0000;
            current_set    <= 16'h0000;
            power_set      <= 16'h0000;
            resistance_set <= 16'h0000;
        end else if (state_reg == ST_ANALOG) begin
            voltage_set    <= clip(voltage_setpoint_input, full);
            current_set    <= clip(current_setpoint_input, full);
            power_set      <= clip(power_setpoint_input, full);
            resistance_set <= clip(resistance_setpoint_input, full);
        end else begin
            voltage_set    <= vset_reg;
            current_set    <= iset_reg;
            power_set      <= pset_reg;
            resistance_set <= 16'h0000;
        end
    end

    // Monitors share the setpoint scale, so both saturate at the same code [R14]
    always @(posedge aclk) begin
        if (!aresetn) begin
            voltage_monitor_output <= 16'h0000;
            current_monitor_output <= 16'h0000;
        end else begin
            voltage_monitor_output <= clip(voltage_actual, full);
            current_monitor_output <= clip(current_actual, full);
        end
    end

    // Output switch, alarm pins and logging
    always @(posedge aclk) begin
        if (!aresetn) begin
            terminal_on    <= 1'b0;
            alarm_port_1   <= 1'b0;
            alarm_port_2   <= 1'b0;
            logging_active <= 1'b0;
        end else begin
            // Standby low forces off in every location [R16] [R18]
            terminal_on <= standby_hi & ~any_alarm & ~(|alarm_reg) &
                           (state_reg == ST_ANALOG | ctrl_reg[`RCA_CTRL_OUT_ON]);
            // Safety overvoltage raises both ports [R21] [R19]
            alarm_port_1 <= port_alarm(alarm_reg, almsel_reg, PORT1_MASK);
            alarm_port_2 <= port_alarm(alarm_reg, almsel_reg, PORT2_MASK);
            // Linked logging follows the switch; manual run ignores alarms [R22]
            if (ctrl_reg[`RCA_CTRL_LOG_LINK])
                logging_active <= terminal_on & ~any_alarm;
            else
                logging_active <= ctrl_reg[`RCA_CTRL_LOG_RUN];
        end
    end

    // AXI4-Lite write path
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg     <= 1'b0;
            w_reg      <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg  <= 32'h0000_0000;
            bvalid_reg <= 1'b0;
            bresp_reg  <= `RCA_RESP_OKAY;
            wstrb_reg  <= 4'h0;
        end else begin
            // Each half is taken once, then parked until the write lands
            if (s_axi_awvalid && !aw_reg) begin
                aw_reg     <= 1'b1;
                awaddr_reg <= word_addr(s_axi_awaddr);
            end
            // Strobes travel with the data; the bus may change them once taken
            if (s_axi_wvalid && !w_reg) begin
                w_reg     <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                aw_reg     <= 1'b0;
                w_reg      <= 1'b0;
                if (wr_error)
                    bresp_reg <= `RCA_RESP_SLVERR;
                else
                    bresp_reg <= `RCA_RESP_OKAY;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Reads always answered whoever owns control [R4]
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= `RCA_RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `RCA_RESP_OKAY;
            case (word_addr(s_axi_araddr))
                `RCA_CTRL_OFS:    rdata_reg <= ctrl_reg;
                // State field is one-hot: 1 manual, 2 analog, 4 digital
                `RCA_STATUS_OFS:  rdata_reg <= {24'h0, 1'b0, logging_active, terminal_on,
                                                remote_req, locked, state_reg};
                `RCA_VSET_OFS:    rdata_reg <= {16'h0, voltage_set};
                `RCA_ISET_OFS:    rdata_reg <= {16'h0, current_set};
                `RCA_PSET_OFS:    rdata_reg <= {16'h0, power_set};
                `RCA_OVP_THR_OFS: rdata_reg <= {16'h0, ovp_thr_reg};
                `RCA_ALMSEL_OFS:  rdata_reg <= {26'h0, almsel_reg};
                `RCA_ALARM_OFS:   rdata_reg <= {26'h0, alarm_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= `RCA_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule // rca_arbiter
`default_nettype wire

// ===== rca_map.vh
// Behaviour
// R1: One remote owner: analog or one digital
// R2: Digital request refused while analog input low
// R3: Digital owner ignores external control request input
// R4: Status and value reads always answered
// R5: Neither remote nor lock: manual, accept requests
// R6: Local lock refuses all remote control
// R7: Lock ends digital session; re-request needed
// R8: Lock suspends analog; resumes if still requested
// R9: Analog takes voltage, current, power together
// R10: Analog uses common sink/source current, power
// R11: Analog active shows analog set values
// R12: Range bit selects 5 V or 10 V
// R13: Over-range setpoint clips to full scale
// R14: 26214 steps at 10 V, half at 5 V
// R15: Protection thresholds never set from analog port
// R16: Analog via request input; standby acts always
// R17: Controller ignores alarm outputs until ready
// R18: Any alarm under analog switches output off
// R19: Configuration selects alarms driving alarm outputs
// R20: Protection alarms latched until standby acknowledgement
// R21: Safety overvoltage never acknowledged; shows PF+OVERVOLTAGE_PROTECTION_ALARM
// R22: Linked logging stops on alarm; manual continues
// R23: Standby low timed; short low rejected
`ifndef RCA_MAP_VH
`define RCA_MAP_VH
`define RCA_CTRL_OFS      32'h0000_0000
`define RCA_STATUS_OFS    32'h0000_0004
`define RCA_VSET_OFS      32'h0000_0008
`define RCA_ISET_OFS      32'h0000_000c
`define RCA_PSET_OFS      32'h0000_0010
`define RCA_OVP_THR_OFS   32'h0000_0014
`define RCA_ALMSEL_OFS    32'h0000_0018
`define RCA_ALARM_OFS     32'h0000_001c
`define RCA_CTRL_RST      32'h0000_0000
`define RCA_ALMSEL_RST    6'h1f
`define RCA_OVP_THR_RST   16'hffff
`define RCA_CTRL_REQ_REM  0
`define RCA_CTRL_REL_REM  1
`define RCA_CTRL_LOCK     2
`define RCA_CTRL_RANGE10  3
`define RCA_CTRL_LOG_LINK 4
`define RCA_CTRL_OUT_ON   5
`define RCA_CTRL_LOG_RUN  6
`define RCA_ALM_OVP       0
`define RCA_ALM_OCP       1
`define RCA_ALM_OPP       2
`define RCA_ALM_OT        3
`define RCA_ALM_PF        4
`define RCA_ALM_SAFETY_OVERVOLTAGE_LATCH      5
`define RCA_FULL10        16'd26214
`define RCA_FULL5         16'd13107
`define RCA_ACK_LOW_MS    50
`define RCA_CLK_KHZ       125000
`define RCA_ACK_CYCLES    (`RCA_ACK_LOW_MS * `RCA_CLK_KHZ)
`define RCA_RESP_OKAY     2'b00
`define RCA_RESP_SLVERR   2'b10
`endif

// ===== rca_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rca_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        remote_request_n,
    input wire logic [5:0]  alarm_event,
    input wire logic [15:0] voltage_setpoint_input,
    input wire logic [15:0] power_setpoint_input,
    input wire logic [15:0] voltage_set,
    input wire logic [15:0] power_set,
    input wire logic [15:0] voltage_monitor_output,
    input wire logic [15:0] current_monitor_output,
    input wire logic        range_10v,
    input wire logic        terminal_on,
    input wire logic        alarm_port_2,
    input wire logic        analog_active,
    input wire logic        digital_active,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    wire [15:0] fs = range_10v ? 16'h6666 : 16'h3333;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_own; !(analog_active && digital_active); endproperty
    a_own: assert property (p_own)
        else $error("two owners at once");
    property p_off; |alarm_event |-> ##[1:4] !terminal_on; endproperty
    a_off: assert property (p_off)
        else $error("output stayed on after alarm");
    property p_latch; |alarm_event[2:0] |-> ##[1:4] alarm_port_2 ##1 alarm_port_2; endproperty
    a_latch: assert property (p_latch)
        else $error("protection alarm not held");
    property p_dark; alarm_port_2 |-> !terminal_on; endproperty
    a_dark: assert property (p_dark)
        else $error("output on under alarm");
    // Range held for three samples; flag and monitors register on the same edge, so no sample is stale after a switch
    property p_mon; $stable(range_10v) [*2] |->
        voltage_monitor_output <= fs && current_monitor_output <= fs; endproperty
    a_mon: assert property (p_mon)
        else $error("monitor above full scale");
    property p_entry; $rose(analog_active) |->
        !$past(remote_request_n) && !$past(remote_request_n, 2); endproperty
    a_entry: assert property (p_entry)
        else $error("analog entered without request");
    property p_follow; (analog_active && $stable(voltage_setpoint_input)
        && $stable(power_setpoint_input) && $stable(range_10v)) [*3] |->
        voltage_set == (voltage_setpoint_input > fs ? fs : voltage_setpoint_input)
        && power_set == (power_setpoint_input > fs ? fs : power_setpoint_input); endproperty
    a_follow: assert property (p_follow)
        else $error("set values not from analog port");
    property p_rd; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rd: assert property (p_rd)
        else $error("read answer not retired");
    c_analog: cover property (analog_active);
    c_digital: cover property (digital_active);
    c_ack: cover property ($fell(alarm_port_2));
endmodule // rca_monitor
`default_nettype wire

// ===== rca_partner.sv
`timescale 1ns/10ps
`default_nettype none
module rca_partner (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       want_remote,
    input  wire logic       want_on,
    input  wire logic       ack_go,
    input  wire logic [7:0] ack_len,
    input  wire logic       alarm_port_1,
    input  wire logic       alarm_port_2,
    output var  logic       remote_request_n,
    output var  logic       terminal_standby_input,
    output var  logic [1:0] alarms_seen
);
    logic [7:0] low_cnt;
    initial begin
        low_cnt = 8'h00;
        remote_request_n = 1'h1;
        terminal_standby_input = 1'h1;
        alarms_seen = 2'h0;
    end
    always @(posedge aclk) begin
        remote_request_n <= !want_remote;
        if (ack_go)
            low_cnt <= ack_len;
        else if (low_cnt != 8'h00)
            low_cnt <= low_cnt - 8'h01;
        // Low phase lasts exactly ack_len cycles, so short pulses can be made on purpose
        terminal_standby_input <= want_on && !ack_go && low_cnt < 8'h02;
        // Outputs are undefined until the device is out of reset
        alarms_seen <= aresetn ? {alarm_port_2, alarm_port_1} : 2'h0;
    end
endmodule // rca_partner
`default_nettype wire

// ===== rca_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} rca_row_t;
    rca_row_t rows [5] = '{'{8'h00, 32'h0, 2'h0}, '{8'h14, 32'hffff, 2'h0},
        '{8'h18, 32'h1f, 2'h0}, '{8'h1c, 32'h0, 2'h0}, '{8'h20, 32'h0, 2'h2}};
    logic        aclk = 1'h0, aresetn = 1'h0, want_remote = 1'h0, want_on = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ack_len = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ack_go = 1'h0;
    logic [15:0] voltage_setpoint_input = 16'h0, current_setpoint_input = 16'h0;
    logic [15:0] power_setpoint_input = 16'h0, resistance_setpoint_input = 16'h0;
    logic [15:0] voltage_actual = 16'h0, current_actual = 16'h0;
    logic [5:0]  alarm_event = 6'h00;
    logic [1:0]  r;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp, alarms_seen;
    wire [31:0]  s_axi_rdata;
    wire [15:0]  voltage_set, current_set, power_set, resistance_set;
    wire [15:0]  voltage_monitor_output, current_monitor_output;
    wire         range_10v, terminal_on, alarm_port_1, alarm_port_2, logging_active;
    wire         analog_active, digital_active, remote_request_n, terminal_standby_input;
    int          errors = 0, check_count = 0;

    rca_arbiter #(.ACK_CYCLES(20)) u_rca_arbiter (.*);
    rca_partner u_rca_partner (.*);

    initial begin
        forever #4 aclk = ~aclk;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Both channels offered together; each dropped on its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic ack(input logic [7:0] n);
        ack_len <= n;
        ack_go <= 1'h1;
        @(posedge aclk);
        ack_go <= 1'h0;
        repeat (n + 8) @(posedge aclk);
    endtask
    task automatic pulse(input logic [5:0] v);
        alarm_event <= v;
        @(posedge aclk);
        alarm_event <= 6'h00;
        wt(6);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (int k = 0; k < 5; k++) begin
            rd(rows[k].a, d, r);
            chk("reg data", d, rows[k].d);
            chk("reg resp", r, rows[k].r);
        end
        $display("test register reset done");
        wr(8'h00, 32'h1, r);
        chk("grant resp", r, 2'h0);
        wt(3);
        chk("digital", digital_active, 1'h1);
        want_remote <= 1'h1;
        wt(8);
        chk("pin ignored", analog_active, 1'h0);
        rd(8'h04, d, r);
        chk("status resp", r, 2'h0);
        wr(8'h00, 32'h4, r);
        wt(3);
        chk("lock ends", digital_active, 1'h0);
        chk("lock holds", analog_active, 1'h0);
        wr(8'h00, 32'h5, r);
        chk("locked resp", r, 2'h2);
        wr(8'h00, 32'h0, r);
        wt(8);
        chk("no restore", digital_active, 1'h0);
        chk("resume", analog_active, 1'h1);
        wr(8'h00, 32'h1, r);
        chk("refused", r, 2'h2);
        $display("test control location done");
        voltage_setpoint_input <= 16'h1000;
        current_setpoint_input <= 16'hffff;
        power_setpoint_input <= 16'h2000;
        voltage_actual <= 16'hffff;
        resistance_setpoint_input <= 16'h4000;
        current_actual <= 16'h0100;
        wt(8);
        chk("vset", voltage_set, 16'h1000);
        chk("iset 5v", current_set, 16'h3333);
        chk("pset", power_set, 16'h2000);
        chk("voltage_monitor_output 5v", voltage_monitor_output, 16'h3333);
        chk("rset 5v", resistance_set, 16'h3333);
        chk("current_monitor_output", current_monitor_output, 16'h0100);
        wr(8'h00, 32'h18, r);
        wr(8'h18, 32'h3f, r);
        wr(8'h14, 32'h1234, r);
        chk("thr resp", r, 2'h0);
        rd(8'h14, d, r);
        chk("thr kept", d, 32'h1234);
        wt(8);
        chk("iset 10v", current_set, 16'h6666);
        chk("rset 10v", resistance_set, 16'h4000);
        chk("range", range_10v, 1'h1);
        chk("out on", terminal_on, 1'h1);
        chk("log on", logging_active, 1'h1);
        $display("test analog values done");
        pulse(6'h01);
        chk("alarm off", terminal_on, 1'h0);
        chk("log off", logging_active, 1'h0);
        chk("seen", alarms_seen, 2'h2);
        ack(8'h08);
        chk("short ack", alarm_port_2, 1'h1);
        ack(8'h18);
        chk("ack", alarm_port_2, 1'h0);
        pulse(6'h20);
        ack(8'h18);
        chk("safety_overvoltage_latch ports", {alarm_port_1, alarm_port_2}, 2'h3);
        wr(8'h00, 32'h48, r);
        wt(4);
        chk("manual log", logging_active, 1'h1);
        $display("test alarms done");
        aresetn <= 1'h0;
        wt(3);
        aresetn <= 1'h1;
        wt(1);
        chk("rst owner", {analog_active, digital_active}, 2'h0);
        chk("rst ports", {alarm_port_1, alarm_port_2}, 2'h0);
        rd(8'h1c, d, r);
        chk("rst latch", d, 32'h0);
        wt(8);
        chk("rst resume", analog_active, 1'h1);
        $display("test reset done");
        report_and_stop();
    end
endmodule // tb
bind rca_arbiter rca_monitor u_rca_monitor (.*);
`default_nettype wire
